// file: common/data_eeprom_consts.svh
// Summary of operation
// - Latch access bit alone selects read/write
// - Read mode returns array byte next cycle
// - Write mode captures writes into latches
// - Start bit programs all written latches
// - Row comes from last captured write
// - Erase and program phases internally timed
// - End clears start, access; raises irq
// - Vector fetch withdraws the interrupt request
// - Latches clear at end, access fall
// - Repeated latch write combines by AND
// - Latch contents are never readable
// - Wait entered now, or after cycle
// - Halt stops at once, abandons cycle
// - Array read in write mode undriven
// - Array write in read mode ignored
// - Cut cycle leaves array data unguaranteed
// - Register bits: irq enable, access, start
// - Access clear refused while programming
// - Register at 002Ch, resets to zero
`ifndef DATA_EEPROM_CONSTS_SVH
`define DATA_EEPROM_CONSTS_SVH

`define CSR_ADDR 16'h002C
`define CSR_RESET 8'h00
`define CSR_PAD 5'h00
`define CSR_BIT_IE 2
`define CSR_BIT_LAT 1
`define CSR_BIT_PGM 0
`define ARRAY_BASE_HI 8'h0C
`define ARRAY_WORDS 256
`define LATCH_COUNT 16
`define LATCH_ALL_CLEAR 16'h0000
`define BYTE_CLEAR 8'h00
`define CLK_PERIOD_NS 50
`define ERASE_TIME_NS 100000
`define PROG_TIME_NS 100000
`define ERASE_CYCLES ((`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_CYCLES ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_ZERO 12'h000

`endif

// file: common/data_eeprom_pkg.sv
`default_nettype none
package data_eeprom_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ERASE = 3'b010,
    ST_PROG = 3'b100
  } prog_state_t;

  // One CPU bus access, valid for one cycle
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cpu_req_t;

  typedef struct packed {
    logic ie;
    logic lat;
    logic program_start_bit;
  } ctrl_bits_t;

  typedef struct packed {
    prog_state_t st;
    ctrl_bits_t csr;
    logic [15:0][7:0] latch;
    logic [15:0] latch_used;
    logic [3:0] row;
    logic [11:0] cnt;
    logic irq;
    logic [7:0] rd_data;
    logic data_drive_b;
    logic wait_pend;
    logic wait_mode;
    logic halt_mode;
    logic [255:0][7:0] mem;
  } eeprom_state_t;
endpackage
`default_nettype wire

// file: hdl/data_eeprom_access_ctrl.sv
`include "data_eeprom_consts.svh"
`default_nettype none
module data_eeprom_access_ctrl (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire data_eeprom_pkg::cpu_req_t cpu_req,
  input wire logic vec_fetch,
  input wire logic wfi_instr,
  input wire logic halt_instr,
  input wire logic wake,
  output logic [7:0] rd_data,
  output logic data_drive_b,
  output logic irq_req,
  output logic wait_mode,
  output logic halt_mode
);
  data_eeprom_pkg::eeprom_state_t q;
  data_eeprom_pkg::eeprom_state_t next_q;

  // Address decode
  logic array_hit;
  logic csr_hit;
  logic busy;
  logic array_wr;
  logic prog_done;
  logic lat_fall;
  logic [15:0][7:0] next_latch;
  logic [15:0] next_used;
  assign array_hit = (cpu_req.addr[15:8] == `ARRAY_BASE_HI);
  assign csr_hit = (cpu_req.addr == `CSR_ADDR);
  assign busy = q.csr.program_start_bit;
  // Capture only in write mode with no cycle running
  assign array_wr = cpu_req.wr && array_hit && q.csr.lat && !busy
    && !q.halt_mode;
  assign prog_done = q.st[2] && (q.cnt == `CNT_ZERO);
  assign lat_fall = q.csr.lat && !next_q.csr.lat;

  // Per-latch capture and AND merge
  genvar gi;
  generate
    for (gi = 0; gi < `LATCH_COUNT; gi++) begin : g_latch
      always_comb begin
        next_latch[gi] = q.latch[gi];
        next_used[gi] = q.latch_used[gi];
        if (array_wr && (cpu_req.addr[3:0] == 4'(gi))) begin
          next_latch[gi] = q.latch_used[gi] ? (q.latch[gi] & cpu_req.wdata)
            : cpu_req.wdata;
          next_used[gi] = 1'b1;
        end
      end

      // A fresh latch takes the written byte; a used one is committed at the end
      chk_latch_capture: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (array_wr && cpu_req.addr[3:0] == 4'(gi) && !q.latch_used[gi]) |=>
        (q.latch_used[gi] && q.latch[gi] == $past(cpu_req.wdata)))
        else $error("array write not captured into latch");

      chk_prog_commit: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (prog_done && q.latch_used[gi] && !(cpu_req.wr && csr_hit)) |=>
        (q.mem[{$past(q.row), 4'(gi)}] == $past(q.latch[gi])))
        else $error("used latch not programmed into row");
    end
  endgenerate

  // Next-state logic
  always_comb begin
    next_q = q;
    next_q.data_drive_b = 1'b1;
    next_q.latch = next_latch;
    next_q.latch_used = next_used;
    // Register and array reads; latches have no read path
    if (cpu_req.rd && csr_hit) begin
      next_q.rd_data = {`CSR_PAD, q.csr.ie, q.csr.lat, q.csr.program_start_bit};
      next_q.data_drive_b = 1'b0;
    end else if (cpu_req.rd && array_hit && !q.csr.lat) begin
      next_q.rd_data = q.mem[cpu_req.addr[7:0]];
      next_q.data_drive_b = 1'b0;
    end
    // Row from the most recent captured write
    if (array_wr) begin
      next_q.row = cpu_req.addr[7:4];
    end
    // Software access to the control register
    if (cpu_req.wr && csr_hit) begin
      next_q.csr.ie = cpu_req.wdata[`CSR_BIT_IE];
      if (cpu_req.wdata[`CSR_BIT_LAT]) begin
        next_q.csr.lat = 1'b1;
      end else if (!q.csr.program_start_bit) begin
        next_q.csr.lat = 1'b0;
      end
      if (cpu_req.wdata[`CSR_BIT_PGM] && q.csr.lat && !q.csr.program_start_bit) begin
        next_q.csr.program_start_bit = 1'b1;
        next_q.st = data_eeprom_pkg::ST_ERASE;
        next_q.cnt = 12'(`ERASE_CYCLES - 1);
      end else if (!cpu_req.wdata[`CSR_BIT_PGM] && q.csr.program_start_bit) begin
        next_q.csr.program_start_bit = 1'b0;
        next_q.st = data_eeprom_pkg::ST_IDLE;
      end
    end
    // Internally timed erase then program
    unique case (q.st)
      data_eeprom_pkg::ST_IDLE: begin
      end
      data_eeprom_pkg::ST_ERASE: begin
        if (next_q.st == data_eeprom_pkg::ST_ERASE) begin
          if (q.cnt == `CNT_ZERO) begin
            next_q.st = data_eeprom_pkg::ST_PROG;
            next_q.cnt = 12'(`PROG_CYCLES - 1);
          end else begin
            next_q.cnt = q.cnt - 12'h001;
          end
        end
      end
      data_eeprom_pkg::ST_PROG: begin
        if (next_q.st == data_eeprom_pkg::ST_PROG) begin
          if (prog_done) begin
            for (int i = 0; i < `LATCH_COUNT; i++) begin
              if (q.latch_used[i]) begin
                next_q.mem[{q.row, 4'(i)}] = q.latch[i];
              end
            end
            next_q.csr.program_start_bit = 1'b0;
            next_q.csr.lat = 1'b0;
            next_q.st = data_eeprom_pkg::ST_IDLE;
          end else begin
            next_q.cnt = q.cnt - 12'h001;
          end
        end
      end
      default: begin
        next_q.st = data_eeprom_pkg::ST_IDLE;
      end
    endcase
    // Interrupt request: set wins over vector fetch
    if (prog_done && q.csr.ie && (next_q.st == data_eeprom_pkg::ST_IDLE)) begin
      next_q.irq = 1'b1;
    end else if (vec_fetch) begin
      next_q.irq = 1'b0;
    end
    // Wait mode entry, deferred until the cycle completes
    if (wfi_instr) begin
      next_q.wait_pend = 1'b1;
    end
    if (next_q.wait_pend && !next_q.csr.program_start_bit) begin
      next_q.wait_mode = 1'b1;
      next_q.wait_pend = 1'b0;
    end
    if (wake) begin
      next_q.wait_mode = 1'b0;
      next_q.halt_mode = 1'b0;
    end
    // Halt abandons any cycle at once
    if (halt_instr) begin
      next_q.halt_mode = 1'b1;
      next_q.csr.program_start_bit = 1'b0;
      next_q.st = data_eeprom_pkg::ST_IDLE;
      next_q.wait_pend = 1'b0;
    end
    // Latches empty at the end of a cycle and whenever write mode is left
    if (prog_done || (q.csr.lat && !next_q.csr.lat)) begin
      next_q.latch = {`LATCH_COUNT{`BYTE_CLEAR}};
      next_q.latch_used = `LATCH_ALL_CLEAR;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.st <= data_eeprom_pkg::ST_IDLE;
      q.csr <= 3'(`CSR_RESET);
      q.data_drive_b <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign rd_data = q.rd_data;
  assign data_drive_b = q.data_drive_b;
  assign irq_req = q.irq;
  assign wait_mode = q.wait_mode;
  assign halt_mode = q.halt_mode;

  // Read mode answers the next cycle with the array byte
  chk_read_mode_data: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cpu_req.rd && array_hit && !csr_hit && !q.csr.lat) |=>
    (!data_drive_b && rd_data == $past(q.mem[cpu_req.addr[7:0]])))
    else $error("array read did not return data");

  chk_write_mode_float: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cpu_req.rd && array_hit && !csr_hit && q.csr.lat) |=> data_drive_b)
    else $error("array read in write mode drove bus");

  chk_read_mode_ignore: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cpu_req.wr && array_hit && !q.csr.lat && !(cpu_req.wr && csr_hit)) |=>
    $stable(q.latch))
    else $error("write in read mode changed latches");

  chk_latch_and_merge: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (array_wr && q.latch_used[cpu_req.addr[3:0]] && !prog_done && !lat_fall) |=>
    q.latch[$past(cpu_req.addr[3:0])] == ($past(q.latch[cpu_req.addr[3:0]])
    & $past(cpu_req.wdata)))
    else $error("repeated latch write not ANDed");

  chk_end_clears_bits: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (prog_done && !halt_instr && !(cpu_req.wr && csr_hit)) |=>
    (!q.csr.program_start_bit && !q.csr.lat && q.latch_used == `LATCH_ALL_CLEAR
    && irq_req == $past(q.csr.ie || irq_req && !vec_fetch)))
    else $error("end of cycle did not clear control bits");

  chk_irq_vec_fetch: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (irq_req && vec_fetch && !prog_done) |=> !irq_req)
    else $error("vector fetch did not withdraw request");

  chk_lat_clear_busy: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (q.csr.program_start_bit && cpu_req.wr && csr_hit && cpu_req.wdata[`CSR_BIT_PGM]
    && !cpu_req.wdata[`CSR_BIT_LAT] && !prog_done && !halt_instr) |=> q.csr.lat)
    else $error("access bit cleared during programming");

  chk_pgm_needs_lat: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!q.csr.lat && !q.csr.program_start_bit) |=> !q.csr.program_start_bit)
    else $error("programming started from read mode");

  chk_busy_no_capture: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (q.csr.program_start_bit && !prog_done && !lat_fall) |=> $stable(q.latch_used))
    else $error("latches altered while programming");

  chk_halt_stops: assert property (@(posedge sys_clk) disable iff (!rst_b)
    halt_instr |=> (halt_mode && !q.csr.program_start_bit && q.st == data_eeprom_pkg::ST_IDLE))
    else $error("halt did not stop the cycle");

  chk_wait_deferred: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wfi_instr && !wake) |=> (wait_mode == !q.csr.program_start_bit) || halt_mode)
    else $error("wait entry not as required");

  chk_erase_then_prog: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (q.st == data_eeprom_pkg::ST_ERASE && q.cnt == `CNT_ZERO && q.csr.program_start_bit
    && !halt_instr && !(cpu_req.wr && csr_hit)) |=> (q.st == data_eeprom_pkg::ST_PROG))
    else $error("erase did not chain into program");

  // Register reads and bus drive
  chk_csr_read_value: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cpu_req.rd && csr_hit) |=> (!data_drive_b && rd_data == {`CSR_PAD,
    $past(q.csr.ie), $past(q.csr.lat), $past(q.csr.program_start_bit)}))
    else $error("control register read value wrong");

  chk_no_stray_drive: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(cpu_req.rd && (csr_hit || (array_hit && !q.csr.lat))) |=> data_drive_b)
    else $error("bus driven without an answered read");

  // Control register writes
  chk_lat_set_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cpu_req.wr && csr_hit && cpu_req.wdata[`CSR_BIT_LAT] && !prog_done) |=> q.csr.lat)
    else $error("access bit not set by write");

  chk_ie_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cpu_req.wr && csr_hit) |=> (q.csr.ie == $past(cpu_req.wdata[`CSR_BIT_IE])))
    else $error("interrupt enable not written");

  chk_pgm_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cpu_req.wr && csr_hit && cpu_req.wdata[`CSR_BIT_PGM] && q.csr.lat && !q.csr.program_start_bit
    && !halt_instr) |=> (q.csr.program_start_bit && q.st == data_eeprom_pkg::ST_ERASE
    && q.cnt == 12'(`ERASE_CYCLES - 1)))
    else $error("programming cycle did not start");

  chk_sw_abort: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cpu_req.wr && csr_hit && !cpu_req.wdata[`CSR_BIT_PGM] && q.csr.program_start_bit) |=>
    (!q.csr.program_start_bit && q.st == data_eeprom_pkg::ST_IDLE))
    else $error("software abort did not stop the cycle");

  // Internal timing of both phases
  chk_erase_countdown: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (q.st == data_eeprom_pkg::ST_ERASE && q.cnt != `CNT_ZERO && !halt_instr
    && !(cpu_req.wr && csr_hit)) |=>
    (q.st == data_eeprom_pkg::ST_ERASE && q.cnt == $past(q.cnt) - 12'h001))
    else $error("erase counter did not step");

  chk_prog_countdown: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (q.st == data_eeprom_pkg::ST_PROG && q.cnt != `CNT_ZERO && !halt_instr
    && !(cpu_req.wr && csr_hit)) |=>
    (q.st == data_eeprom_pkg::ST_PROG && q.cnt == $past(q.cnt) - 12'h001))
    else $error("program counter did not step");

  chk_prog_to_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (prog_done && !(cpu_req.wr && csr_hit)) |=> (q.st == data_eeprom_pkg::ST_IDLE))
    else $error("cycle did not return to idle");

  // Interrupt request only from the end of a cycle, held until the vector fetch
  chk_irq_source: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!irq_req && !(prog_done && q.csr.ie)) |=> !irq_req)
    else $error("interrupt raised without end of cycle");

  chk_irq_holds: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (irq_req && !vec_fetch) |=> irq_req)
    else $error("interrupt dropped without vector fetch");

  // Latch clearing
  chk_latch_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!prog_done && !lat_fall && !array_wr) |=> $stable(q.latch_used))
    else $error("latches changed without cause");

  chk_lat_fall_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
    lat_fall |=> (q.latch_used == `LATCH_ALL_CLEAR))
    else $error("leaving write mode kept latches");

  // Array and row bookkeeping
  chk_mem_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !prog_done |=> $stable(q.mem))
    else $error("array changed outside cycle end");

  chk_row_capture: assert property (@(posedge sys_clk) disable iff (!rst_b)
    array_wr |=> (q.row == $past(cpu_req.addr[7:4])))
    else $error("row not taken from captured write");

  chk_row_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !array_wr |=> $stable(q.row))
    else $error("row changed without captured write");

  // Power saving modes
  chk_wait_idle_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!wait_mode && !wfi_instr && !q.wait_pend) |=> !wait_mode)
    else $error("wait entered without instruction");

  chk_wake_clears: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wake && !halt_instr) |=> (!wait_mode && !halt_mode))
    else $error("wake did not leave low power");

  chk_halt_keeps_lat: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (halt_instr && !prog_done && !(cpu_req.wr && csr_hit)) |=>
    (q.csr.lat == $past(q.csr.lat)))
    else $error("halt changed the access bit");
endmodule
`default_nettype wire

// file: verification/cpu_bus_model.sv
`default_nettype none
module cpu_bus_model (
  input wire logic sys_clk,
  input wire logic [7:0] rd_data,
  input wire logic data_drive_b,
  output data_eeprom_pkg::cpu_req_t cpu_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bus idle at time zero; data only, no code fetch path
  initial cpu_req = '0;
  // One write; released fields are inverted so stale values never look valid
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cpu_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge sys_clk);
    cpu_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // Two back-to-back reads, first answer discarded
  task automatic rd2(input logic [15:0] a, output logic [7:0] d, output logic drv_b);
    @(posedge sys_clk);
    cpu_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    repeat (2) @(posedge sys_clk);
    cpu_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
    #1;
    d = rd_data;
    drv_b = data_drive_b;
  endtask
endmodule
`default_nettype wire

// file: verification/data_eeprom_access_ctrl_test.sv
`default_nettype none
module data_eeprom_access_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic vec_fetch = 1'b0, wfi_instr = 1'b0, halt_instr = 1'b0, wake = 1'b0;
  logic [7:0] rd_data, d, a, b, c;
  logic data_drive_b, irq_req, wait_mode, halt_mode, drv_b;
  logic [3:0] row, ix;
  logic [31:0] seed = 32'had06_9a4d;
  int n_fail = 0, checked = 0;
  data_eeprom_pkg::cpu_req_t cpu_req;
  // Clock of 50 ns
  always #25 sys_clk = ~sys_clk;
  cpu_bus_model cpu_bus_model_i (.sys_clk(sys_clk), .rd_data(rd_data),
    .data_drive_b(data_drive_b), .cpu_req(cpu_req));
  data_eeprom_access_ctrl data_eeprom_access_ctrl_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .cpu_req(cpu_req), .vec_fetch(vec_fetch), .wfi_instr(wfi_instr), .halt_instr(halt_instr),
    .wake(wake), .rd_data(rd_data), .data_drive_b(data_drive_b), .irq_req(irq_req),
    .wait_mode(wait_mode), .halt_mode(halt_mode));
  // Xorshift source with fixed seed
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Array address inside the chosen row
  function automatic logic [15:0] ad(input logic [3:0] i);
    return {8'h0C, row, i};
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, e, g);
    end
  endtask
  // Double read, then compare drive enable and, when driven, the data
  task automatic rdc(input logic [15:0] adr, input logic [7:0] e, input logic drv);
    cpu_bus_model_i.rd2(adr, d, drv_b);
    chk("data_drive_b", {7'h00, drv}, {7'h00, drv_b});
    if (drv === 1'b0) chk("rd_data", e, d);
  endtask
  // One-cycle pulse of {vec_fetch, wfi_instr, halt_instr, wake}
  task automatic ev(input logic [3:0] v);
    @(posedge sys_clk);
    {vec_fetch, wfi_instr, halt_instr, wake} <= v;
    @(posedge sys_clk);
    {vec_fetch, wfi_instr, halt_instr, wake} <= 4'h0;
    #1;
  endtask
  // Wait for end of cycle, then withdraw the request by vector fetch
  task automatic prog_end();
    for (int i = 0; i < 4200 && irq_req !== 1'b1; i++) @(posedge sys_clk);
    #1;
    chk("irq_req", 8'h01, {7'h00, irq_req});
    ev(4'h8);
    chk("irq_req", 8'h00, {7'h00, irq_req});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog at 40000 clocks, about five times the two full programming cycles run
  initial begin
    #(40000 * 50);
    n_fail++;
    summarize();
  end
  // Main sequence; all array writes stay in one row
  initial begin
    {row, ix} = rnd();
    a = rnd();
    b = rnd();
    c = rnd();
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdc(16'h002C, 8'h00, 1'b0);
    cpu_bus_model_i.wr(ad(ix), a);
    rdc(ad(ix), 8'h00, 1'b0);
    cpu_bus_model_i.wr(16'h002C, 8'h01);
    rdc(16'h002C, 8'h00, 1'b0);
    cpu_bus_model_i.wr(16'h002C, 8'h02);
    rdc(16'h002C, 8'h02, 1'b0);
    cpu_bus_model_i.wr(ad(ix), a);
    rdc(ad(ix), 8'h00, 1'b1);
    $display("test modes done");
    cpu_bus_model_i.wr(ad(ix), b);
    cpu_bus_model_i.wr(ad(ix ^ 4'h1), c);
    cpu_bus_model_i.wr(16'h002C, 8'h07);
    ev(4'h4);
    chk("wait_mode", 8'h00, {7'h00, wait_mode});
    cpu_bus_model_i.wr(ad(ix), 8'h00);
    cpu_bus_model_i.wr(16'h002C, 8'h05);
    rdc(16'h002C, 8'h07, 1'b0);
    prog_end();
    chk("wait_mode", 8'h01, {7'h00, wait_mode});
    ev(4'h1);
    rdc(16'h002C, 8'h04, 1'b0);
    rdc(ad(ix), a & b, 1'b0);
    rdc(ad(ix ^ 4'h1), c, 1'b0);
    rdc(ad(ix ^ 4'h2), 8'h00, 1'b0);
    $display("test program done");
    cpu_bus_model_i.wr(16'h002C, 8'h02);
    cpu_bus_model_i.wr(ad(ix ^ 4'h2), c);
    cpu_bus_model_i.wr(16'h002C, 8'h00);
    cpu_bus_model_i.wr(16'h002C, 8'h06);
    cpu_bus_model_i.wr(16'h002C, 8'h07);
    prog_end();
    rdc(ad(ix ^ 4'h2), 8'h00, 1'b0);
    $display("test latch clear done");
    ev(4'h4);
    chk("wait_mode", 8'h01, {7'h00, wait_mode});
    ev(4'h1);
    cpu_bus_model_i.wr(16'h002C, 8'h06);
    cpu_bus_model_i.wr(ad(ix), 8'h00);
    cpu_bus_model_i.wr(16'h002C, 8'h07);
    ev(4'h2);
    chk("halt_mode", 8'h01, {7'h00, halt_mode});
    ev(4'h1);
    rdc(16'h002C, 8'h06, 1'b0);
    chk("irq_req", 8'h00, {7'h00, irq_req});
    $display("test halt done");
    summarize();
  end
endmodule
`default_nettype wire
